// file: hdl/external_pin_interrupt_unit.sv
// External pin and pin-change interrupt unit with APB register access
//
// Contract
// - Pin levels raise interrupts even when the pins are driven as outputs.
// - Group two watches inputs 16..23, group one inputs 8..14.
// - One mask register per group picks contributing pin-change inputs.
// - Pin-change activity is seen without the clock, to wake from sleep.
// - Enabled low-level mode requests continuously while the pin stays low.
// - Edges on dedicated pins are recognised only while the clock runs.
// - Low level on dedicated pins is seen without the clock, to wake.
// - A level gone before start-up ends wakes but gives no interrupt.
// - Sense codes: 00 low, 01 any change, 10 falling, 11 rising.
// - Pin one sense in bits 3..2, pin zero sense in bits 1..0.
// - Pins are sampled before edge detection; longer pulses always trigger.
// - Pin request forwarded only with its enable and the global flag.
// - Flag set on trigger, cleared by vector entry or writing one.
// - In low-level mode the pin's flag stays cleared.
// - Unused upper register bits read as zero.
// - Group flag set on any trigger, cleared by vector or writing one.
// - Mask bit enables its pin only while the group enable is set.
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module external_pin_interrupt_unit (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  clk_en,
    // APB slave
    input  wire logic [11:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Pins
    input  wire logic                  ext_irq_pin_zero,
    input  wire logic                  ext_irq_pin_one,
    input  wire logic [`PC_W-1:0]      pin_change_inputs,
    // CPU side
    input  wire logic                  global_int_en,
    input  wire logic [`EXT_W-1:0]     ext_vector_ack,
    input  wire logic [`GRP_W-1:0]     group_vector_ack,
    output logic      [`EXT_W-1:0]     ext_req,
    output logic                       pin_change_group_zero_req,
    output logic                       pin_change_group_one_req,
    output logic                       pin_change_group_two_req,
    // Wake and interrupt
    output logic                       async_wake,
    output logic                       irq
);
    // Registers
    logic [`EXT_W-1:0]  ext_int_enable_ff;
    logic [`GRP_W-1:0]  group_enable_ff;
    logic [3:0]         sense_ff;
    logic [7:0]         mask_ff [`GRP_W];
    logic [`EXT_W-1:0]  ext_flag_ff;
    logic [`GRP_W-1:0]  group_flag_ff;
    logic [`EVT_W-1:0]  irq_status_ff;
    logic [`EVT_W-1:0]  irq_mask_ff;
    logic [`EXT_W-1:0]  ext_prev_ff;
    logic [`PC_W-1:0]   pc_prev_ff;
    logic [`GRP_W-1:0]  pc_hit_ff;
    logic [31:0]        prdata_ff;
    logic               slverr_ff;

    logic [`EXT_W-1:0]  nxt_ext_flag;
    logic [`GRP_W-1:0]  nxt_group_flag;
    logic [`EVT_W-1:0]  nxt_irq_status;

    // Synchronised pins
    logic [`SYNC_W-1:0] sync_lvl;
    logic [`EXT_W-1:0]  ext_lvl;
    logic [`PC_W-1:0]   pc_lvl;
    logic [`EXT_W-1:0]  ext_trig;
    logic [`EXT_W-1:0]  ext_low;
    logic [`EXT_W-1:0]  ext_low_mode;
    logic [`GRP_W-1:0]  group_hit;
    logic [`PC_W-1:0]   pc_eff_mask;
    logic [`EXT_W-1:0]  raw_ext;

    // Bus decode
    wire [`IDX_W-1:0] idx;
    wire              setup_ph;
    wire              access_ph;
    wire              wr;
    wire              we_enable;
    wire              we_group_en;
    wire              we_sense;
    wire              we_ext_flags;
    wire              we_group_flags;
    wire              we_irq_status;
    wire              we_irq_mask;
    wire [`GRP_W-1:0] we_mask;

    function automatic logic addr_hit(input logic [`IDX_W-1:0] i);
        if (i == `IDX_EXT_INT_ENABLE)       addr_hit = 1'b1;
        else if (i == `IDX_GROUP_ENABLE)    addr_hit = 1'b1;
        else if (i == `IDX_SENSE_CONTROL)   addr_hit = 1'b1;
        else if (i == `IDX_MASK_GROUP_ZERO) addr_hit = 1'b1;
        else if (i == `IDX_MASK_GROUP_ONE)  addr_hit = 1'b1;
        else if (i == `IDX_MASK_GROUP_TWO)  addr_hit = 1'b1;
        else if (i == `IDX_EXT_INT_FLAGS)   addr_hit = 1'b1;
        else if (i == `IDX_GROUP_FLAGS)     addr_hit = 1'b1;
        else if (i == `IDX_IRQ_STATUS)      addr_hit = 1'b1;
        else if (i == `IDX_IRQ_MASK)        addr_hit = 1'b1;
        else                                addr_hit = 1'b0;
    endfunction : addr_hit

    assign idx            = paddr[11:2];
    assign setup_ph       = psel & ~penable;
    assign access_ph      = psel & penable;
    assign wr             = access_ph & pwrite & ~slverr_ff;
    assign we_enable      = wr & (idx == `IDX_EXT_INT_ENABLE);
    assign we_group_en    = wr & (idx == `IDX_GROUP_ENABLE);
    assign we_sense       = wr & (idx == `IDX_SENSE_CONTROL);
    assign we_ext_flags   = wr & (idx == `IDX_EXT_INT_FLAGS);
    assign we_group_flags = wr & (idx == `IDX_GROUP_FLAGS);
    assign we_irq_status  = wr & (idx == `IDX_IRQ_STATUS);
    assign we_irq_mask    = wr & (idx == `IDX_IRQ_MASK);
    assign we_mask[0]     = wr & (idx == `IDX_MASK_GROUP_ZERO);
    assign we_mask[1]     = wr & (idx == `IDX_MASK_GROUP_ONE);
    assign we_mask[2]     = wr & (idx == `IDX_MASK_GROUP_TWO);

    function automatic logic [31:0] read_mux(input logic [`IDX_W-1:0] i);
        if (i == `IDX_EXT_INT_ENABLE)       read_mux = {30'h0, ext_int_enable_ff};
        else if (i == `IDX_GROUP_ENABLE)    read_mux = {29'h0, group_enable_ff};
        else if (i == `IDX_SENSE_CONTROL)   read_mux = {28'h0, sense_ff};
        else if (i == `IDX_MASK_GROUP_ZERO) read_mux = {24'h0, mask_ff[0]};
        else if (i == `IDX_MASK_GROUP_ONE)  read_mux = {24'h0, mask_ff[1]};
        else if (i == `IDX_MASK_GROUP_TWO)  read_mux = {24'h0, mask_ff[2]};
        else if (i == `IDX_EXT_INT_FLAGS)   read_mux = {30'h0, ext_flag_ff};
        else if (i == `IDX_GROUP_FLAGS)     read_mux = {29'h0, group_flag_ff};
        else if (i == `IDX_IRQ_STATUS)      read_mux = {27'h0, irq_status_ff};
        else if (i == `IDX_IRQ_MASK)        read_mux = {27'h0, irq_mask_ff};
        else                                read_mux = 32'h0;
    endfunction : read_mux

    // pin level taken whatever its port direction
    assign raw_ext = {ext_irq_pin_one, ext_irq_pin_zero};

    pin_sync3 #(
        .W (`SYNC_W)
    ) u_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .async_in ({pin_change_inputs, raw_ext}),
        .sync_out (sync_lvl)
    );

    assign ext_lvl = sync_lvl[`EXT_W-1:0];
    assign pc_lvl  = sync_lvl[`SYNC_W-1:`EXT_W];

    genvar gp;
    generate
        for (gp = 0; gp < `EXT_W; gp++)
        begin : g_pin
            ext_irq_pkg::sense_mode_t mode;
            assign mode = ext_irq_pkg::sense_mode_t'(sense_ff[2*gp+1 -: 2]);
            assign ext_low_mode[gp] = (mode == ext_irq_pkg::SENSE_LOW);
            // edges seen on the clock only
            sense_detect u_sense (
                .level      (ext_lvl[gp]),
                .prev       (ext_prev_ff[gp]),
                .mode       (mode),
                .trig       (ext_trig[gp]),
                .low_active (ext_low[gp])
            );
        end
    endgenerate

    generate
        for (gp = 0; gp < `GRP_W; gp++)
        begin : g_grp
            assign pc_eff_mask[8*gp+7 -: 8] = mask_ff[gp] & {8{group_enable_ff[gp]}};
            assign group_hit[gp] = |((pc_lvl[8*gp+7 -: 8] ^ pc_prev_ff[8*gp+7 -: 8])
                                     & pc_eff_mask[8*gp+7 -: 8]);
        end
    endgenerate

    assign nxt_ext_flag   = ~ext_low_mode & (ext_trig | (ext_flag_ff &
                            ~ext_vector_ack & ~({`EXT_W{we_ext_flags}} & pwdata[`EXT_W-1:0])));
    assign nxt_group_flag = pc_hit_ff | (group_flag_ff & ~group_vector_ack &
                            ~({`GRP_W{we_group_flags}} & pwdata[`GRP_W-1:0]));
    assign nxt_irq_status = {pc_hit_ff, ext_trig} | (irq_status_ff &
                            ~({`EVT_W{we_irq_status}} & pwdata[`EVT_W-1:0]));

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ext_prev_ff   <= `REG_RESET_2;
            pc_prev_ff    <= '0;
            pc_hit_ff     <= `REG_RESET_3;
            ext_flag_ff   <= `REG_RESET_2;
            group_flag_ff <= `REG_RESET_3;
            irq_status_ff <= `REG_RESET_5;
        end
        else if (clk_en)
        begin
            ext_prev_ff   <= ext_lvl;
            pc_prev_ff    <= pc_lvl;
            pc_hit_ff     <= group_hit;
            ext_flag_ff   <= nxt_ext_flag;
            group_flag_ff <= nxt_group_flag;
            irq_status_ff <= nxt_irq_status;
        end
    end

    // Control registers written at the access edge
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ext_int_enable_ff <= `REG_RESET_2;
            group_enable_ff   <= `REG_RESET_3;
            sense_ff          <= '0;
            irq_mask_ff       <= `REG_RESET_5;
            for (int i = 0; i < `GRP_W; i++)
                mask_ff[i] <= `REG_RESET_8;
        end
        else if (clk_en)
        begin
            if (we_enable)
                ext_int_enable_ff <= pwdata[`EXT_W-1:0];
            if (we_group_en)
                group_enable_ff <= pwdata[`GRP_W-1:0];
            if (we_sense)
                sense_ff <= pwdata[3:0];
            if (we_irq_mask)
                irq_mask_ff <= pwdata[`EVT_W-1:0];
            if (we_mask[0])
                mask_ff[0] <= pwdata[7:0];
            // bit seven of group one reads zero
            if (we_mask[1])
                mask_ff[1] <= pwdata[7:0] & `MASK_ONE_VALID;
            if (we_mask[2])
                mask_ff[2] <= pwdata[7:0];
        end
    end

    // Read data captured in setup so it comes from a flop
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            prdata_ff <= 32'h0;
            slverr_ff <= 1'b0;
        end
        else if (clk_en && setup_ph)
        begin
            prdata_ff <= read_mux(idx);
            slverr_ff <= ~addr_hit(idx) | (paddr[1:0] != 2'h0);
        end
    end

    // Zero wait: a frozen clock enable would otherwise stall the bus
    assign pready  = 1'b1;
    assign pslverr = access_ph & slverr_ff;
    assign prdata  = prdata_ff;

    assign ext_req = ext_int_enable_ff & {`EXT_W{global_int_en}} &
                     ((ext_low_mode & ext_low) | (~ext_low_mode & ext_flag_ff));
    assign pin_change_group_zero_req = group_enable_ff[0] & global_int_en & group_flag_ff[0];
    assign pin_change_group_one_req  = group_enable_ff[1] & global_int_en & group_flag_ff[1];
    assign pin_change_group_two_req  = group_enable_ff[2] & global_int_en & group_flag_ff[2];

    // wake does not wait for the synchronised request
    assign async_wake = |(~raw_ext & ext_low_mode & ext_int_enable_ff) |
                        |((pin_change_inputs ^ pc_prev_ff) & pc_eff_mask);

    assign irq = |(irq_status_ff & irq_mask_ff);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    AST_LEVEL_REQ: assert property (
        (ext_int_enable_ff[0] && global_int_en && ext_low_mode[0] && !ext_lvl[0])
            |-> ext_req[0])
        else $error("low level request missing");

    AST_LEVEL_FLAG: assert property (
        (ext_low_mode[1] && $past(ext_low_mode[1])) |-> !ext_flag_ff[1])
        else $error("flag set in level mode");

    AST_FORWARD: assert property (
        ext_req[1] |-> (ext_int_enable_ff[1] && global_int_en))
        else $error("request without enable");

    AST_RISE_FLAG: assert property (
        (clk_en && sense_ff[1:0] == ext_irq_pkg::SENSE_RISE && !ext_prev_ff[0] && ext_lvl[0])
            |=> ext_flag_ff[0])
        else $error("rising edge not flagged");

    AST_FALL_ONLY: assert property (
        (clk_en && sense_ff[3:2] == ext_irq_pkg::SENSE_FALL && !ext_flag_ff[1]
            && !(ext_prev_ff[1] && !ext_lvl[1])) |=> !ext_flag_ff[1])
        else $error("falling mode flagged without fall");

    AST_W1C: assert property (
        (clk_en && we_ext_flags && pwdata[0] && !ext_trig[0]) |=> !ext_flag_ff[0])
        else $error("write one did not clear flag");

    AST_MISMATCH: assert property (
        (clk_en && group_hit[2]) |=> (pc_hit_ff[2] and (clk_en |=> group_flag_ff[2])))
        else $error("mismatch did not set flag in time");

    AST_MASK: assert property (
        !group_enable_ff[1] |-> !group_hit[1])
        else $error("disabled group hit");

    AST_RESERVED: assert property (
        access_ph |-> (prdata[31:8] == 24'h0))
        else $error("upper bits not zero");

    AST_WAKE: assert property (
        (ext_int_enable_ff[0] && ext_low_mode[0] && !ext_irq_pin_zero) |-> async_wake)
        else $error("no wake on low level");

    COV_LEVEL: cover property (ext_req[0] && ext_low_mode[0]);
    COV_GROUP: cover property (pin_change_group_two_req);
    COV_IRQ:   cover property ($rose(irq) ##[1:20] !irq);
endmodule : external_pin_interrupt_unit

// file: hdl/ext_irq_params.svh
// Register indices, field positions and reset values of the external pin interrupt unit
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

`define IDX_W               10
`define IDX_EXT_INT_ENABLE  10'h03d
`define IDX_GROUP_ENABLE    10'h068
`define IDX_SENSE_CONTROL   10'h069
`define IDX_MASK_GROUP_ZERO 10'h06b
`define IDX_MASK_GROUP_ONE  10'h06c
`define IDX_MASK_GROUP_TWO  10'h06d
`define IDX_EXT_INT_FLAGS   10'h070
`define IDX_GROUP_FLAGS     10'h071
`define IDX_IRQ_STATUS      10'h072
`define IDX_IRQ_MASK        10'h073

`define REG_RESET_8         8'h00
`define REG_RESET_5         5'h00
`define REG_RESET_3         3'h0
`define REG_RESET_2         2'h0
`define MASK_ONE_VALID      8'h7f

`define SENSE_ZERO_LSB      0
`define SENSE_ONE_LSB       2
`define EXT_W               2
`define GRP_W               3
`define EVT_W               5
`define PC_W                24
`define SYNC_W              26

`endif

// file: hdl/ext_irq_pkg.sv
// Types shared by the external pin interrupt unit
package ext_irq_pkg;
    typedef enum logic [1:0]
    {
        SENSE_LOW    = 2'b00,
        SENSE_CHANGE = 2'b01,
        SENSE_FALL   = 2'b10,
        SENSE_RISE   = 2'b11
    } sense_mode_t;
endpackage : ext_irq_pkg

// file: hdl/pin_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    // Pins
    input  wire logic [W-1:0] async_in,
    // Clean levels
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] nxt_out;

    // Stage one feeds stage two only
    assign nxt_out = (s2_ff & s3_ff) | (out_ff & (s2_ff ^ s3_ff));

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            out_ff <= '0;
        end
        else if (clk_en)
        begin
            s1_ff  <= async_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign sync_out = out_ff;
endmodule : pin_sync3

// file: hdl/sense_detect.sv
// Sense decoder for one dedicated interrupt pin
`timescale 1ns/1ps
module sense_detect (
    // Pin history
    input  wire logic                     level,
    input  wire logic                     prev,
    // Mode
    input  wire ext_irq_pkg::sense_mode_t mode,
    // Results
    output logic                          trig,
    output logic                          low_active
);
    wire rise;
    wire fall;
    wire is_low_mode;

    assign rise        = level & ~prev;
    assign fall        = ~level & prev;
    assign is_low_mode = (mode == ext_irq_pkg::SENSE_LOW);
    assign trig        = (mode == ext_irq_pkg::SENSE_CHANGE) ? (rise | fall) :
                         (mode == ext_irq_pkg::SENSE_FALL)   ? fall :
                         (mode == ext_irq_pkg::SENSE_RISE)   ? rise : 1'b0;
    assign low_active  = is_low_mode & ~level;
endmodule : sense_detect

// file: sim/pin_source.sv
// Board-side model driving the dedicated and pin-change interrupt pins
`timescale 1ns/1ps
module pin_source (
    // Clock
    input  wire logic        sys_clk,
    // Requested levels
    input  wire logic        want_zero,
    input  wire logic        want_one,
    input  wire logic [23:0] want_pc,
    // Pins
    output logic             ext_irq_pin_zero,
    output logic             ext_irq_pin_one,
    output logic      [23:0] pin_change_inputs
);
    initial
    begin
        ext_irq_pin_zero  = 1'b1;
        ext_irq_pin_one   = 1'b1;
        pin_change_inputs = 24'h000000;
    end

    // levels held whole cycles
    // Pins move only on an edge, so every pulse spans at least one whole clock
    always @(posedge sys_clk)
    begin
        ext_irq_pin_zero  <= want_zero;
        ext_irq_pin_one   <= want_one;
        pin_change_inputs <= want_pc;
    end
endmodule : pin_source

// file: sim/external_pin_interrupt_unit_tb.sv
// Self-checking bench of the external pin interrupt unit
`timescale 1ns/1ps
`include "ext_irq_params.svh"
module external_pin_interrupt_unit_tb;
    logic        sys_clk;
    logic        nrst, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pin0, pin1, want_zero, want_one, global_int_en, err;
    logic [23:0] pcin, want_pc;
    logic [1:0]  ext_vector_ack, ext_req;
    logic [2:0]  group_vector_ack, grp_req;
    logic        async_wake, irq;
    int          num_errors, total_checks, m, e, g, b;

    external_pin_interrupt_unit i_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pin_zero(pin0),
        .ext_irq_pin_one(pin1), .pin_change_inputs(pcin), .global_int_en(global_int_en),
        .ext_vector_ack(ext_vector_ack), .group_vector_ack(group_vector_ack),
        .ext_req(ext_req), .pin_change_group_zero_req(grp_req[0]),
        .pin_change_group_one_req(grp_req[1]), .pin_change_group_two_req(grp_req[2]),
        .async_wake(async_wake), .irq(irq));

    pin_source i_pins (.sys_clk(sys_clk), .want_zero(want_zero), .want_one(want_one),
        .want_pc(want_pc), .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1),
        .pin_change_inputs(pcin));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic exp_flag(input logic [1:0] mode, input logic rise);
        case (mode)
            ext_irq_pkg::SENSE_CHANGE: return 1'b1;
            ext_irq_pkg::SENSE_FALL:   return ~rise;
            ext_irq_pkg::SENSE_RISE:   return rise;
            default:                   return 1'b0;
        endcase
    endfunction : exp_flag

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    // Called just after an edge; data and error taken at the pready edge
    // One idle edge after release, so back-to-back calls never re-drive psel
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (n >= 50)
        begin
            $display("CHECK FAILED pready expected 1 seen 0");
            num_errors++;
            close_out();
        end
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp, input string name);
        apb(1'b0, idx, 32'h0);
        check(name, exp, rd);
    endtask : rchk

    task automatic pulse_ack(input logic [1:0] ea, input logic [2:0] ga);
        ext_vector_ack   <= ea;
        group_vector_ack <= ga;
        @(posedge sys_clk);
        ext_vector_ack   <= 2'h0;
        group_vector_ack <= 3'h0;
        idle(2);
    endtask : pulse_ack

    initial
    begin
        nrst = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; want_zero = 1'b1; want_one = 1'b1;
        want_pc = 24'h0; global_int_en = 1'b0; ext_vector_ack = 2'h0;
        group_vector_ack = 3'h0; num_errors = 0; total_checks = 0;
        void'($urandom(32'h9c4e4fa1));
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        idle(10);
        rchk(`IDX_EXT_INT_ENABLE, 32'h0, "enable reset");
        rchk(`IDX_GROUP_ENABLE, 32'h0, "group enable reset");
        rchk(`IDX_SENSE_CONTROL, 32'h0, "sense reset");
        rchk(`IDX_EXT_INT_FLAGS, 32'h0, "flags reset");
        wr(`IDX_SENSE_CONTROL, 32'hff);
        rchk(`IDX_SENSE_CONTROL, 32'h0f, "sense upper bits");
        wr(`IDX_EXT_INT_ENABLE, 32'hff);
        rchk(`IDX_EXT_INT_ENABLE, 32'h03, "enable upper bits");
        wr(`IDX_GROUP_ENABLE, 32'hff);
        rchk(`IDX_GROUP_ENABLE, 32'h07, "group enable upper bits");
        b = $urandom;
        wr(`IDX_MASK_GROUP_ONE, b);
        rchk(`IDX_MASK_GROUP_ONE, b & 32'h7f, "mask one bits");
        apb(1'b0, 10'h3ff, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        wr(`IDX_GROUP_ENABLE, 32'h0);
        wr(`IDX_EXT_INT_ENABLE, 32'h0);
        $display("test registers done");
        for (m = 0; m < 4; m++)
        begin
            wr(`IDX_SENSE_CONTROL, {28'h0, m[1:0], m[1:0]});
            for (e = 0; e < 2; e++)
            begin
                want_zero <= e[0];
                want_one  <= e[0];
                idle(10);
                rchk(`IDX_EXT_INT_FLAGS, {30'h0, {2{exp_flag(m[1:0], e[0])}}}, "flags");
                wr(`IDX_EXT_INT_FLAGS, 32'h3);
                rchk(`IDX_EXT_INT_FLAGS, 32'h0, "flags cleared");
            end
        end
        wr(`IDX_SENSE_CONTROL, 32'h0e);
        want_zero <= 1'b0;
        want_one  <= 1'b0;
        idle(10);
        rchk(`IDX_EXT_INT_FLAGS, 32'h1, "split fields fall");
        want_zero <= 1'b1;
        want_one  <= 1'b1;
        idle(10);
        rchk(`IDX_EXT_INT_FLAGS, 32'h3, "split fields rise");
        wr(`IDX_EXT_INT_FLAGS, 32'h3);
        $display("test sense modes done");
        wr(`IDX_SENSE_CONTROL, 32'h0);
        wr(`IDX_EXT_INT_ENABLE, 32'h3);
        global_int_en <= 1'b1;
        want_zero <= 1'b0;
        idle(10);
        check("level request", 32'h1, {30'h0, ext_req});
        idle(25);
        check("level request held", 32'h1, {30'h0, ext_req});
        global_int_en <= 1'b0;
        idle(1);
        check("global gate", 32'h0, {30'h0, ext_req});
        global_int_en <= 1'b1;
        want_zero <= 1'b1;
        idle(10);
        check("level released", 32'h0, {30'h0, ext_req});
        wr(`IDX_SENSE_CONTROL, 32'h0f);
        want_one <= 1'b0;
        idle(10);
        want_one <= 1'b1;
        idle(10);
        check("edge request", 32'h2, {30'h0, ext_req});
        pulse_ack(2'h2, 3'h0);
        check("vector clears", 32'h0, {30'h0, ext_req});
        $display("test requests done");
        wr(`IDX_GROUP_ENABLE, 32'h7);
        for (g = 0; g < 3; g++)
        begin
            b = 8 * g + $urandom_range(g == 1 ? 6 : 7, 0);
            wr(10'(`IDX_MASK_GROUP_ZERO + g), 32'h0);
            want_pc <= want_pc ^ (24'h1 << b);
            idle(10);
            rchk(`IDX_GROUP_FLAGS, 32'h0, "masked pin");
            wr(10'(`IDX_MASK_GROUP_ZERO + g), 32'h1 << (b - 8 * g));
            want_pc <= want_pc ^ (24'h1 << b);
            idle(10);
            rchk(`IDX_GROUP_FLAGS, 32'h1 << g, "group flag");
            check("group request", 32'h1 << g, {29'h0, grp_req});
            pulse_ack(2'h0, 3'h1 << g);
            rchk(`IDX_GROUP_FLAGS, 32'h0, "group vector clears");
            wr(10'(`IDX_MASK_GROUP_ZERO + g), 32'h0);
        end
        wr(`IDX_GROUP_ENABLE, 32'h3);
        wr(`IDX_MASK_GROUP_TWO, 32'hff);
        want_pc <= want_pc ^ 24'hff0000;
        idle(10);
        rchk(`IDX_GROUP_FLAGS, 32'h0, "group disabled");
        $display("test pin change done");
        wr(`IDX_GROUP_ENABLE, 32'h1);
        wr(`IDX_MASK_GROUP_ZERO, 32'h1);
        wr(`IDX_IRQ_STATUS, 32'h1f);
        wr(`IDX_IRQ_MASK, 32'h04);
        want_pc <= want_pc ^ 24'h1;
        idle(10);
        check("irq raised", 32'h1, {31'h0, irq});
        rchk(`IDX_IRQ_STATUS, 32'h04, "irq status");
        wr(`IDX_IRQ_MASK, 32'h0);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(`IDX_IRQ_MASK, 32'h04);
        wr(`IDX_IRQ_STATUS, 32'h04);
        check("irq cleared", 32'h0, {31'h0, irq});
        wr(`IDX_GROUP_FLAGS, 32'h7);
        $display("test interrupt done");
        wr(`IDX_SENSE_CONTROL, 32'h0);
        wr(`IDX_EXT_INT_ENABLE, 32'h1);
        clk_en <= 1'b0;
        want_zero <= 1'b0;
        idle(3);
        check("low level wake", 32'h1, {31'h0, async_wake});
        want_zero <= 1'b1;
        idle(3);
        clk_en <= 1'b1;
        idle(10);
        check("short level no request", 32'h0, {30'h0, ext_req});
        wr(`IDX_SENSE_CONTROL, 32'h03);
        clk_en <= 1'b0;
        want_zero <= 1'b0;
        idle(3);
        want_zero <= 1'b1;
        idle(3);
        clk_en <= 1'b1;
        idle(10);
        rchk(`IDX_EXT_INT_FLAGS, 32'h0, "edge while frozen");
        clk_en <= 1'b0;
        want_pc <= want_pc ^ 24'h1;
        idle(3);
        check("pin change wake", 32'h1, {31'h0, async_wake});
        clk_en <= 1'b1;
        idle(10);
        $display("test sleep done");
        close_out();
    end
endmodule : external_pin_interrupt_unit_tb
